// ===== src/capwm_channel.sv
// Purpose: Waveform and edge detection of one PWM channel
// Assumes: Duty value already masked to the cycle length
// Notes:   Pin is registered, one clock behind the counter
`default_nettype none
module capwm_channel (
  input  wire logic                   clock,
  input  wire logic                   srst,
  input  wire logic [10:0]            cnt,
  input  wire logic                   wrap,
  input  wire capwm_pkg::capwm_len_type len,
  input  wire logic                   enable,
  input  wire logic                   center,
  input  wire logic [10:0]            duty,
  output logic                        pin,
  output logic                        reload_pt,
  output logic                        event_pt
);
  import capwm_pkg::*;

  logic        pin_reg;
  logic        pin_next;
  logic [11:0] period;
  logic [11:0] start;
  logic [11:0] stop;
  logic        up_edge;
  logic        match_edge;
  logic        edge_lvl;
  logic        center_lvl;

  always_comb begin
    period     = {1'b0, capwm_period_top(len)} + 12'h001;
    start      = (period - {1'b0, duty}) >> 1;
    stop       = start + {1'b0, duty};
    up_edge    = ({1'b0, cnt} == start);
    match_edge = (cnt == duty);
    edge_lvl   = (cnt < duty);
    center_lvl = ({1'b0, cnt} >= start) && ({1'b0, cnt} < stop);
    pin_next   = enable && (center ? center_lvl : edge_lvl);
    reload_pt  = enable && (center ? up_edge : wrap);
    event_pt   = enable && (center ? up_edge : match_edge);
  end

  always_ff @(posedge clock) begin
    if (srst) begin
      pin_reg <= 1'b0;
    end else begin
      pin_reg <= pin_next;
    end
  end

  assign pin = pin_reg;

  default clocking cb @(posedge clock); endclocking
  default disable iff (srst);

  AST_EDGE_PIN: assert property ((enable && !center) |=> pin == $past(edge_lvl))
    else $error("Edge-aligned pin does not follow the counter compare");
  AST_CENTER_UP: assert property ((enable && center && up_edge && duty != 11'h000) |=> pin)
    else $error("Center-aligned pin not high after up edge");
  AST_IDLE_LOW: assert property (!enable |=> !pin)
    else $error("Pin driven while channel not in PWM mode");
endmodule
`default_nettype wire

// ===== src/capwm_pkg.sv
// Purpose: Shared constants and types of the counter array PWM block
// Assumes: 8-bit register port, three channels, 11-bit timebase
// Notes:   All register offsets live here, and the field positions except length select [1:0], run bit 0 and the event flag bits
`default_nettype none
package capwm_pkg;
  localparam int unsigned CAPWM_NUM_CH = 3;
  localparam int unsigned CAPWM_CNT_W  = 11;

  typedef logic [7:0] capwm_byte_type;
  typedef logic [CAPWM_CNT_W-1:0] capwm_cnt_type;

  typedef enum logic [1:0] {
    CAPWM_LEN8  = 2'b00,
    CAPWM_LEN9  = 2'b01,
    CAPWM_LEN10 = 2'b10,
    CAPWM_LEN11 = 2'b11
  } capwm_len_type;

  typedef struct packed {
    capwm_byte_type addr;
    capwm_byte_type wdata;
    logic           wr;
    logic           rd;
  } capwm_bus_req_type;

  // Register offsets
  localparam capwm_byte_type CAPWM_ADDR_RUN    = 8'h00;
  localparam capwm_byte_type CAPWM_ADDR_CFG    = 8'h01;
  localparam capwm_byte_type CAPWM_ADDR_CNT_LO = 8'h02;
  localparam capwm_byte_type CAPWM_ADDR_CNT_HI = 8'h03;
  localparam capwm_byte_type CAPWM_ADDR_FLAGS  = 8'h04;
  localparam capwm_byte_type CAPWM_ADDR_CH0    = 8'h10;
  localparam capwm_byte_type CAPWM_CH_STRIDE   = 8'h04;
  localparam logic [1:0]     CAPWM_OFS_MODE    = 2'h0;
  localparam logic [1:0]     CAPWM_OFS_LOW     = 2'h1;
  localparam logic [1:0]     CAPWM_OFS_HIGH    = 2'h2;

  // Field positions
  localparam int unsigned CAPWM_CFG_RELOAD_SELECT   = 5;
  localparam int unsigned CAPWM_CFG_CYCLE_OVERFLOW_FLAG    = 6;
  localparam int unsigned CAPWM_MODE_CENTER = 0;
  localparam int unsigned CAPWM_MODE_PWM    = 1;
  localparam int unsigned CAPWM_MODE_MAT    = 3;
  localparam int unsigned CAPWM_MODE_ECOM   = 6;

  // Values after reset
  localparam capwm_byte_type CAPWM_BYTE_RESET = 8'h00;
  localparam capwm_cnt_type  CAPWM_CNT_RESET  = 11'h000;

  // Top count of the selected cycle length
  function automatic capwm_cnt_type capwm_period_top(input capwm_len_type len);
    case (len)
      CAPWM_LEN8:  capwm_period_top = 11'h0FF;
      CAPWM_LEN9:  capwm_period_top = 11'h1FF;
      CAPWM_LEN10: capwm_period_top = 11'h3FF;
      default:     capwm_period_top = 11'h7FF;
    endcase
  endfunction
endpackage
`default_nettype wire

// ===== src/capwm_timebase.sv
// Purpose: Shared counter timebase of the counter array
// Assumes: Counts one step per clock while running
// Notes:   Wrap marks the overflow edge of the selected cycle length
`default_nettype none
module capwm_timebase (
  input  wire logic                   clock,
  input  wire logic                   srst,
  input  wire logic                   run,
  input  wire capwm_pkg::capwm_len_type len,
  output logic  [10:0]                cnt,
  output logic                        wrap
);
  import capwm_pkg::*;

  capwm_cnt_type cnt_reg;
  capwm_cnt_type cnt_next;
  capwm_cnt_type top;

  always_comb begin
    top      = capwm_period_top(len);
    wrap     = run && (cnt_reg >= top);
    cnt_next = cnt_reg;
    if (wrap) begin
      cnt_next = CAPWM_CNT_RESET;
    end else if (run) begin
      cnt_next = cnt_reg + 11'h001;
    end
  end

  always_ff @(posedge clock) begin
    if (srst) begin
      cnt_reg <= CAPWM_CNT_RESET;
    end else begin
      cnt_reg <= cnt_next;
    end
  end

  assign cnt = cnt_reg;

  default clocking cb @(posedge clock); endclocking
  default disable iff (srst);

  AST_COMMON_LEN: assert property (wrap |=> cnt_reg == 11'h000)
    else $error("Counter did not restart after overflow");
endmodule
`default_nettype wire

// ===== src/capwm_top.sv
// Purpose: PWM channel logic of the counter array with its registers
// Assumes: Register port, write one cycle, read data one cycle later
// Notes:   Three channels share one timebase and one cycle length
//
// Operation
// - All PWM channels share one cycle length
// - Non-PWM channels run independently, pin held low; here they also raise no events and get no reloads
// - Each channel picks edge or center alignment
// - 8-bit duty comes from compare low byte
// - 8-bit mode reloads low from high byte
// - 8-bit PWM: enables set, length select 00b
// - Match or up edge sets event flag
// - 8-bit overflow flag every 256 counts
// - Wide modes take low N compare bits
// - Auto-reload register shares compare byte addresses
// - Reload select steers compare byte accesses
// - Wide modes reload compare from auto-reload
// - Wide PWM: enables set, length not 8
// - Wide modes set overflow flag at overflow
// - Low write clears enable, high sets it
//
// Our own choices: the placing of the registers and the plain strobed port.
`default_nettype none
module capwm_top (
  input  wire logic                        clock,
  input  wire logic                        srst,
  input  wire capwm_pkg::capwm_bus_req_type bus_req,
  output logic [7:0]                       rd_data,
  output logic [2:0]                       channel_output_pin
);
  import capwm_pkg::*;

  localparam int unsigned NCH = CAPWM_NUM_CH;

  // Control and status state
  logic           run_reg;
  logic           run_next;
  capwm_len_type  len_reg;
  capwm_len_type  len_next;
  logic           reload_select_reg;
  logic           reload_select_next;
  logic           cycle_overflow_flag_reg;
  logic           cycle_overflow_flag_next;
  logic [NCH-1:0] evt_reg;
  logic [NCH-1:0] evt_next;
  capwm_byte_type cnt_hi_reg;
  capwm_byte_type cnt_hi_next;
  capwm_byte_type rdata_reg;
  capwm_byte_type rdata_next;

  // Per-channel storage
  capwm_byte_type mode_reg [NCH];
  capwm_byte_type mode_next[NCH];
  capwm_byte_type cpl_reg  [NCH];
  capwm_byte_type cpl_next [NCH];
  capwm_byte_type cph_reg  [NCH];
  capwm_byte_type cph_next [NCH];
  capwm_byte_type arl_reg  [NCH];
  capwm_byte_type arl_next [NCH];
  capwm_byte_type arh_reg  [NCH];
  capwm_byte_type arh_next [NCH];

  // Channel wiring
  capwm_cnt_type  cnt;
  logic           wrap;
  capwm_cnt_type  top;
  logic [NCH-1:0] pwm_on;
  logic [NCH-1:0] center;
  logic [NCH-1:0] reload_pt;
  logic [NCH-1:0] event_pt;
  capwm_cnt_type  duty[NCH];

  // Channel register hit and index
  function automatic logic ch_hit(input capwm_byte_type addr, input logic [1:0] ofs);
    logic [7:0] rel;
    rel = addr - CAPWM_ADDR_CH0;
    ch_hit = (addr >= CAPWM_ADDR_CH0) && (rel < 8'(NCH * 4)) && (rel[1:0] == ofs);
  endfunction

  function automatic int unsigned ch_idx(input capwm_byte_type addr);
    logic [7:0] rel;
    rel = addr - CAPWM_ADDR_CH0;
    ch_idx = 32'(rel[7:2]);
  endfunction

  capwm_timebase u_timebase (
    .clock (clock),
    .srst  (srst),
    .run   (run_reg),
    .len   (len_reg),
    .cnt   (cnt),
    .wrap  (wrap)
  );

  // Active duty per channel
  always_comb begin
    top = capwm_period_top(len_reg);
    for (int c = 0; c < NCH; c++) begin
      pwm_on[c] = mode_reg[c][CAPWM_MODE_ECOM] && mode_reg[c][CAPWM_MODE_PWM];
      center[c] = mode_reg[c][CAPWM_MODE_CENTER];
      if (len_reg == CAPWM_LEN8) begin
        duty[c] = {3'b000, cpl_reg[c]};
      end else begin
        duty[c] = {cph_reg[c][2:0], cpl_reg[c]} & top;
      end
    end
  end

  for (genvar g = 0; g < NCH; g++) begin : g_ch
    capwm_channel u_channel (
      .clock     (clock),
      .srst      (srst),
      .cnt       (cnt),
      .wrap      (wrap),
      .len       (len_reg),
      .enable    (pwm_on[g]),
      .center    (center[g]),
      .duty      (duty[g]),
      .pin       (channel_output_pin[g]),
      .reload_pt (reload_pt[g]),
      .event_pt  (event_pt[g])
    );
  end

  // Next state of all registers
  always_comb begin
    int unsigned ci;
    ci          = ch_idx(bus_req.addr);
    run_next    = run_reg;
    len_next    = len_reg;
    reload_select_next  = reload_select_reg;
    cycle_overflow_flag_next   = cycle_overflow_flag_reg;
    evt_next    = evt_reg;
    cnt_hi_next = cnt_hi_reg;
    rdata_next  = CAPWM_BYTE_RESET;
    for (int c = 0; c < NCH; c++) begin
      mode_next[c] = mode_reg[c];
      cpl_next[c]  = cpl_reg[c];
      cph_next[c]  = cph_reg[c];
      arl_next[c]  = arl_reg[c];
      arh_next[c]  = arh_reg[c];
    end
    // Automatic duty reload
    for (int c = 0; c < NCH; c++) begin
      if (run_reg && pwm_on[c] && reload_pt[c]) begin
        if (len_reg == CAPWM_LEN8) begin
          cpl_next[c] = cph_reg[c];
        end else begin
          cpl_next[c] = arl_reg[c];
          cph_next[c] = arh_reg[c];
        end
      end
    end
    // Software writes
    if (bus_req.wr) begin
      if (bus_req.addr == CAPWM_ADDR_RUN) begin
        run_next = bus_req.wdata[0];
      end else if (bus_req.addr == CAPWM_ADDR_CFG) begin
        len_next   = capwm_len_type'(bus_req.wdata[1:0]);
        reload_select_next = bus_req.wdata[CAPWM_CFG_RELOAD_SELECT];
        cycle_overflow_flag_next  = cycle_overflow_flag_reg && bus_req.wdata[CAPWM_CFG_CYCLE_OVERFLOW_FLAG];
      end else if (bus_req.addr == CAPWM_ADDR_FLAGS) begin
        evt_next = evt_reg & bus_req.wdata[NCH-1:0];
      end else if (ch_hit(bus_req.addr, CAPWM_OFS_MODE)) begin
        mode_next[ci] = bus_req.wdata;
      end else if (ch_hit(bus_req.addr, CAPWM_OFS_LOW)) begin
        if (reload_select_reg) begin
          arl_next[ci] = bus_req.wdata;
        end else begin
          cpl_next[ci] = bus_req.wdata;
          mode_next[ci][CAPWM_MODE_ECOM] = 1'b0;
        end
      end else if (ch_hit(bus_req.addr, CAPWM_OFS_HIGH)) begin
        if (reload_select_reg) begin
          arh_next[ci] = bus_req.wdata;
        end else begin
          cph_next[ci] = bus_req.wdata;
          mode_next[ci][CAPWM_MODE_ECOM] = 1'b1;
        end
      end
    end
    // Hardware sets win over software clears
    if (wrap) begin
      cycle_overflow_flag_next = 1'b1;
    end
    for (int c = 0; c < NCH; c++) begin
      if (run_reg && event_pt[c] && mode_reg[c][CAPWM_MODE_MAT]) begin
        evt_next[c] = 1'b1;
      end
    end
    // Software reads, counter high byte latched with the low byte
    if (bus_req.rd) begin
      if (bus_req.addr == CAPWM_ADDR_RUN) begin
        rdata_next = {7'h00, run_reg};
      end else if (bus_req.addr == CAPWM_ADDR_CFG) begin
        rdata_next = {1'b0, cycle_overflow_flag_reg, reload_select_reg, 3'b000, len_reg};
      end else if (bus_req.addr == CAPWM_ADDR_CNT_LO) begin
        rdata_next  = cnt[7:0];
        cnt_hi_next = {5'h00, cnt[10:8]};
      end else if (bus_req.addr == CAPWM_ADDR_CNT_HI) begin
        rdata_next = cnt_hi_reg;
      end else if (bus_req.addr == CAPWM_ADDR_FLAGS) begin
        rdata_next = {5'h00, evt_reg};
      end else if (ch_hit(bus_req.addr, CAPWM_OFS_MODE)) begin
        rdata_next = mode_reg[ci];
      end else if (ch_hit(bus_req.addr, CAPWM_OFS_LOW)) begin
        rdata_next = reload_select_reg ? arl_reg[ci] : cpl_reg[ci];
      end else if (ch_hit(bus_req.addr, CAPWM_OFS_HIGH)) begin
        rdata_next = reload_select_reg ? arh_reg[ci] : cph_reg[ci];
      end
    end
  end

  always_ff @(posedge clock) begin
    if (srst) begin
      run_reg    <= 1'b0;
      len_reg    <= CAPWM_LEN8;
      reload_select_reg  <= 1'b0;
      cycle_overflow_flag_reg   <= 1'b0;
      evt_reg    <= '0;
      cnt_hi_reg <= CAPWM_BYTE_RESET;
      rdata_reg  <= CAPWM_BYTE_RESET;
      for (int c = 0; c < NCH; c++) begin
        mode_reg[c] <= CAPWM_BYTE_RESET;
        cpl_reg[c]  <= CAPWM_BYTE_RESET;
        cph_reg[c]  <= CAPWM_BYTE_RESET;
        arl_reg[c]  <= CAPWM_BYTE_RESET;
        arh_reg[c]  <= CAPWM_BYTE_RESET;
      end
    end else begin
      run_reg    <= run_next;
      len_reg    <= len_next;
      reload_select_reg  <= reload_select_next;
      cycle_overflow_flag_reg   <= cycle_overflow_flag_next;
      evt_reg    <= evt_next;
      cnt_hi_reg <= cnt_hi_next;
      rdata_reg  <= rdata_next;
      for (int c = 0; c < NCH; c++) begin
        mode_reg[c] <= mode_next[c];
        cpl_reg[c]  <= cpl_next[c];
        cph_reg[c]  <= cph_next[c];
        arl_reg[c]  <= arl_next[c];
        arh_reg[c]  <= arh_next[c];
      end
    end
  end

  assign rd_data = rdata_reg;

  // Lap length watch for the 8-bit overflow period
  logic [8:0] lap_reg;
  logic [8:0] lap_next;
  logic       lap_ok_reg;
  logic       lap_ok_next;

  always_comb begin
    lap_next    = lap_reg + 9'h001;
    lap_ok_next = lap_ok_reg && run_reg && (len_reg == CAPWM_LEN8);
    if (wrap) begin
      lap_next    = 9'h000;
      lap_ok_next = 1'b1;
    end
  end

  always_ff @(posedge clock) begin
    if (srst) begin
      lap_reg    <= 9'h000;
      lap_ok_reg <= 1'b0;
    end else begin
      lap_reg    <= lap_next;
      lap_ok_reg <= lap_ok_next;
    end
  end

  // Checks
  default clocking cb @(posedge clock); endclocking
  default disable iff (srst);

  logic wr_ch0_low;
  logic wr_ch0_high;
  logic rd_ch0_low;
  logic quiet_bus;
  logic wr_ch1_low;
  logic flag_wr;
  logic cfg_wr;
  logic cnt_lo_rd;
  assign wr_ch0_low  = bus_req.wr && bus_req.addr == CAPWM_ADDR_CH0 + 8'h01;
  assign wr_ch0_high = bus_req.wr && bus_req.addr == CAPWM_ADDR_CH0 + 8'h02;
  assign rd_ch0_low  = bus_req.rd && bus_req.addr == CAPWM_ADDR_CH0 + 8'h01;
  assign quiet_bus   = !bus_req.wr;
  assign wr_ch1_low  = bus_req.wr && bus_req.addr == CAPWM_ADDR_CH0 + CAPWM_CH_STRIDE + 8'h01;
  assign flag_wr     = bus_req.wr && bus_req.addr == CAPWM_ADDR_FLAGS;
  assign cfg_wr      = bus_req.wr && bus_req.addr == CAPWM_ADDR_CFG;
  assign cnt_lo_rd   = bus_req.rd && bus_req.addr == CAPWM_ADDR_CNT_LO;

  AST_8BIT_DUTY: assert property ((len_reg == CAPWM_LEN8) |-> duty[0] == {3'b000, cpl_reg[0]})
    else $error("8-bit duty not taken from low byte");
  AST_8BIT_RELOAD: assert property ((run_reg && len_reg == CAPWM_LEN8 && pwm_on[0]
      && reload_pt[0] && quiet_bus) |=> cpl_reg[0] == $past(cph_reg[0]))
    else $error("8-bit low byte not reloaded from high byte");
  AST_EVT_SET: assert property ((run_reg && event_pt[0] && mode_reg[0][CAPWM_MODE_MAT])
      |=> evt_reg[0])
    else $error("Event flag not set on match edge");
  AST_CYCLE_OVERFLOW_FLAG_256: assert property ((run_reg && len_reg == CAPWM_LEN8 && cnt == 11'h0FF)
      |=> cycle_overflow_flag_reg)
    else $error("Overflow flag not set at 8-bit overflow");
  AST_N_DUTY: assert property ((len_reg == CAPWM_LEN9) |-> duty[0][10:9] == 2'b00)
    else $error("Wide duty not limited to selected resolution");
  AST_RELOAD_SELECT_READ: assert property ((rd_ch0_low && reload_select_reg) |=> rd_data == $past(arl_reg[0]))
    else $error("Reload select did not steer the read");
  AST_WIDE_RELOAD: assert property ((run_reg && len_reg != CAPWM_LEN8 && pwm_on[1]
      && reload_pt[1] && quiet_bus)
      |=> {cph_reg[1], cpl_reg[1]} == $past({arh_reg[1], arl_reg[1]}))
    else $error("Compare value not reloaded from auto-reload");
  AST_CYCLE_OVERFLOW_FLAG_WIDE: assert property ((len_reg == CAPWM_LEN11 && wrap) |=> cycle_overflow_flag_reg)
    else $error("Overflow flag not set in wide mode");
  AST_WR_LOW_CLR: assert property ((wr_ch0_low && !reload_select_reg)
      |=> !mode_reg[0][CAPWM_MODE_ECOM] ##1 !pwm_on[0] || $past(wr_ch0_high))
    else $error("Low byte write did not clear compare enable");
  AST_WR_HIGH_SET: assert property ((wr_ch0_high && !reload_select_reg) |=> mode_reg[0][CAPWM_MODE_ECOM])
    else $error("High byte write did not set compare enable");
  AST_CYCLE_OVERFLOW_FLAG_LAP: assert property ((wrap && len_reg == CAPWM_LEN8 && lap_ok_reg)
      |-> lap_reg == 9'(capwm_period_top(CAPWM_LEN8)))
    else $error("8-bit overflows not 256 counts apart");
  AST_EVT_STOPPED: assert property ((!run_reg && !flag_wr) |=> $stable(evt_reg))
    else $error("Event flag changed while the counter was stopped");
  AST_RD_IDLE: assert property (!bus_req.rd |=> rd_data == CAPWM_BYTE_RESET)
    else $error("Read data not cleared outside a read");
  AST_CNT_LATCH: assert property (cnt_lo_rd |=> cnt_hi_reg == {5'h00, $past(cnt[10:8])})
    else $error("Counter high bits not latched with the low byte");
  AST_CYCLE_OVERFLOW_FLAG_CLR: assert property ((cfg_wr && !bus_req.wdata[CAPWM_CFG_CYCLE_OVERFLOW_FLAG] && !wrap)
      |=> !cycle_overflow_flag_reg)
    else $error("Overflow flag not cleared by software");
  AST_RELOAD_SELECT_WRITE: assert property ((wr_ch1_low && reload_select_reg)
      |=> arl_reg[1] == $past(bus_req.wdata) && $stable(mode_reg[1]))
    else $error("Reload register write reached the compare side");

  COV_8BIT_RUN: cover property (run_reg && len_reg == CAPWM_LEN8 && pwm_on[0] && reload_pt[0]);
  COV_WIDE_RUN: cover property (run_reg && len_reg == CAPWM_LEN11 && pwm_on[1] && wrap);
  COV_CENTER: cover property (pwm_on[0] && center[0] && event_pt[0]);
  COV_LAP: cover property (wrap && len_reg == CAPWM_LEN8 && lap_ok_reg);
  COV_FLAG_RACE: cover property (bus_req.wr && bus_req.addr == CAPWM_ADDR_CFG && wrap);
endmodule
`default_nettype wire

// ===== test/capwm_pin_load.sv
// Purpose: Load circuit on the PWM pins, integrates high time
// Assumes: Pins are sampled on the rising clock edge
// Notes:   Clear starts a new measuring window for all channels
`default_nettype none
module capwm_pin_load (
  input  wire logic              clock,
  input  wire logic              clear,
  input  wire logic [2:0]        pin,
  output var  logic [2:0][11:0]  high_cnt
);
  timeunit 1ns;
  timeprecision 1ps;

  // High time per channel
  always_ff @(posedge clock) begin
    for (int i = 0; i < 3; i++) begin
      if (clear) begin
        high_cnt[i] <= 12'h000;
      end else begin
        high_cnt[i] <= high_cnt[i] + 12'(pin[i]);
      end
    end
  end
endmodule
`default_nettype wire

// ===== test/capwm_top_test.sv
// Purpose: Self-checking bench of the counter array PWM block
// Assumes: 100 MHz clock, register port with one-cycle read data
// Notes:   Pin load integrates high time over whole periods
`default_nettype none
`define CHK(got, exp) begin \
  n_tests++; \
  if ((got) !== (exp)) begin \
    fail_count++; \
    $display("[ERR] t=%0t got=%h exp=%h", $time, got, exp); \
  end \
end
module capwm_top_test;
  timeunit 1ns;
  timeprecision 1ps;
  import capwm_pkg::*;

  logic              clock;
  logic              srst;
  capwm_bus_req_type bus_req;
  logic [7:0]        rd_data;
  logic [2:0]        channel_output_pin;
  logic              clear;
  logic [2:0][11:0]  high_cnt;
  logic [31:0]       lfsr;
  logic [7:0]        d;
  int                fail_count;
  int                n_tests;
  int                cycles;

  capwm_top u_capwm_top (
    .clock              (clock),
    .srst               (srst),
    .bus_req            (bus_req),
    .rd_data            (rd_data),
    .channel_output_pin (channel_output_pin)
  );

  capwm_pin_load u_capwm_pin_load (
    .clock    (clock),
    .clear    (clear),
    .pin      (channel_output_pin),
    .high_cnt (high_cnt)
  );

  function automatic logic [31:0] lfsr_next(input logic [31:0] s);
    lfsr_next = {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
  endfunction

  function automatic capwm_byte_type ch_addr(input int n, input logic [1:0] ofs);
    ch_addr = CAPWM_ADDR_CH0 + 8'(n) * CAPWM_CH_STRIDE + 8'(ofs);
  endfunction

  // High cycles per period: duty masked to the cycle length
  function automatic logic [11:0] exp_high(input logic [10:0] v, input int len);
    exp_high = 12'(v & 11'((1 << (8 + len)) - 1));
  endfunction

  task automatic wr(input capwm_byte_type a, input capwm_byte_type v);
    @(posedge clock);
    bus_req.addr  <= a;
    bus_req.wdata <= v;
    bus_req.wr    <= 1'b1;
    @(posedge clock);
    bus_req.wr    <= 1'b0;
  endtask

  task automatic chk_rd(input capwm_byte_type a, input capwm_byte_type e);
    @(posedge clock);
    bus_req.addr <= a;
    bus_req.rd   <= 1'b1;
    @(posedge clock);
    bus_req.rd   <= 1'b0;
    #1;
    `CHK(rd_data, e)
  endtask

  task automatic measure(input int p);
    @(posedge clock);
    clear <= 1'b1;
    @(posedge clock);
    clear <= 1'b0;
    repeat (p) @(posedge clock);
    #1;
  endtask

  task automatic summarize();
    if (fail_count == 0 && n_tests > 0) begin
      $display("Finished cleanly");
    end else begin
      $display("Finished with errors");
    end
    $finish;
  endtask

  initial begin
    clock = 1'b0;
  end

  always #5 clock = ~clock;

  // Hang guard
  always @(posedge clock) begin
    cycles <= cycles + 1;
    if (cycles == 20000) begin
      fail_count++;
      summarize();
    end
  end

  initial begin
    srst       = 1'b1;
    bus_req    = '0;
    clear      = 1'b0;
    lfsr       = 32'h58dc;
    fail_count = 0;
    n_tests    = 0;
    cycles     = 0;
    repeat (5) @(posedge clock);
    srst <= 1'b0;
    chk_rd(CAPWM_ADDR_CFG, 8'h00);
    chk_rd(ch_addr(0, CAPWM_OFS_MODE), 8'h00);
    wr(8'h40, 8'hFF);
    chk_rd(8'h40, 8'h00);
    // Compare byte side effects
    wr(ch_addr(0, CAPWM_OFS_MODE), 8'h4A);
    wr(ch_addr(0, CAPWM_OFS_LOW), 8'h20);
    chk_rd(ch_addr(0, CAPWM_OFS_MODE), 8'h0A);
    wr(ch_addr(0, CAPWM_OFS_HIGH), 8'h20);
    chk_rd(ch_addr(0, CAPWM_OFS_MODE), 8'h4A);
    chk_rd(ch_addr(0, CAPWM_OFS_LOW), 8'h20);
    wr(ch_addr(2, CAPWM_OFS_MODE), 8'h02);
    wr(CAPWM_ADDR_RUN, 8'h01);
    // 8-bit duty through the high byte, edge and center
    for (int i = 0; i < 4; i++) begin
      lfsr = lfsr_next(lfsr);
      d = (i == 0) ? 8'hFF : (i == 3) ? 8'h00 : (lfsr[7:0] | 8'h01);
      wr(ch_addr(0, CAPWM_OFS_MODE), {7'h25, ~i[0]});
      wr(ch_addr(0, CAPWM_OFS_HIGH), d);
      repeat (260) @(posedge clock);
      measure(256);
      `CHK(high_cnt[0], exp_high({3'h0, d}, 0))
      `CHK(high_cnt[2], 12'h000)
    end
    chk_rd(CAPWM_ADDR_FLAGS, 8'h01);
    chk_rd(CAPWM_ADDR_CFG, 8'h40);
    wr(CAPWM_ADDR_RUN, 8'h00);
    wr(CAPWM_ADDR_FLAGS, 8'h00);
    chk_rd(CAPWM_ADDR_FLAGS, 8'h00);
    wr(CAPWM_ADDR_CFG, 8'h00);
    chk_rd(CAPWM_ADDR_CFG, 8'h00);
    // Wide modes through the auto-reload register
    wr(CAPWM_ADDR_CFG, 8'h21);
    wr(ch_addr(1, CAPWM_OFS_MODE), 8'h42);
    wr(ch_addr(1, CAPWM_OFS_LOW), 8'h55);
    wr(ch_addr(1, CAPWM_OFS_HIGH), 8'h03);
    chk_rd(ch_addr(1, CAPWM_OFS_HIGH), 8'h03);
    chk_rd(ch_addr(1, CAPWM_OFS_MODE), 8'h42);
    wr(CAPWM_ADDR_CFG, 8'h01);
    chk_rd(ch_addr(1, CAPWM_OFS_LOW), 8'h00);
    wr(CAPWM_ADDR_RUN, 8'h01);
    for (int len = 1; len < 4; len++) begin
      wr(CAPWM_ADDR_CFG, 8'(len));
      repeat ((1 << (8 + len)) + 8) @(posedge clock);
      measure(1 << (8 + len));
      `CHK(high_cnt[1], exp_high(11'h355, len))
      `CHK(high_cnt[0], 12'h000)
    end
    chk_rd(ch_addr(1, CAPWM_OFS_LOW), 8'h55);
    chk_rd(CAPWM_ADDR_CFG, 8'h43);
    // Mid-run reset, then the latched counter read-back
    @(posedge clock);
    srst <= 1'b1;
    repeat (2) @(posedge clock);
    srst <= 1'b0;
    chk_rd(CAPWM_ADDR_CFG, 8'h00);
    chk_rd(ch_addr(1, CAPWM_OFS_MODE), 8'h00);
    wr(CAPWM_ADDR_CFG, 8'h03);
    wr(CAPWM_ADDR_RUN, 8'h01);
    // Count stands at 564 when the low byte is read
    repeat (563) @(posedge clock);
    chk_rd(CAPWM_ADDR_CNT_LO, 8'h34);
    chk_rd(CAPWM_ADDR_CNT_HI, 8'h02);
    summarize();
  end
endmodule
`undef CHK
`default_nettype wire
